// ### pfh_consts.svh
`ifndef PFH_CONSTS_SVH
`define PFH_CONSTS_SVH

// query word offsets and expected contents of the device
`define PFH_Q_OTP_SIZE_OFS      8'h52
`define PFH_Q_OTP_SIZE_VAL      16'h0009
`define PFH_Q_SW_FEAT_OFS       8'h53
`define PFH_Q_SW_FEAT_VAL       16'h008F
`define PFH_Q_PAGE_SIZE_OFS     8'h54
`define PFH_Q_PAGE_SIZE_VAL     16'h0005
`define PFH_Q_ERS_SUSP_OFS      8'h55
`define PFH_Q_PGM_SUSP_OFS      8'h56
`define PFH_Q_SUSP_VAL          16'h0006
`define PFH_Q_RSVD_FIRST_OFS    8'h57
`define PFH_Q_RSVD_LAST_OFS     8'h77
`define PFH_Q_RSVD_VAL          16'hFFFF
`define PFH_Q_PIN_RST_OFS       8'h78
`define PFH_Q_PIN_RST_VAL       16'h0006
`define PFH_Q_POR_OFS           8'h79
`define PFH_Q_POR_VAL           16'h0009

// bus widths
`define PFH_ADDR_W              26
`define PFH_DATA_W              16

// timing, ns and derived cycles at 5 ns
`define PFH_CLK_PERIOD_NS       5
`define PFH_T_SETUP_NS          10
`define PFH_T_STROBE_NS         70
`define PFH_T_HOLD_NS           10
`define PFH_T_RESET_NS          500
`define PFH_SETUP_CYC  ((`PFH_T_SETUP_NS + `PFH_CLK_PERIOD_NS - 1) / `PFH_CLK_PERIOD_NS)
`define PFH_STROBE_CYC ((`PFH_T_STROBE_NS + `PFH_CLK_PERIOD_NS - 1) / `PFH_CLK_PERIOD_NS)
`define PFH_HOLD_CYC   ((`PFH_T_HOLD_NS + `PFH_CLK_PERIOD_NS - 1) / `PFH_CLK_PERIOD_NS)
`define PFH_RESET_CYC  ((`PFH_T_RESET_NS + `PFH_CLK_PERIOD_NS - 1) / `PFH_CLK_PERIOD_NS)

`endif

// ### pfh_flash_model.sv
module pfh_flash_model
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        wp_n,
    input  wire logic [25:0] addr,
    input  wire logic        corrupt,
    output logic      [15:0] dout,
    output logic             rb_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last_reg;
    logic [5:0]  busy_reg;
    logic        fail_reg;
    logic        we_reg;
    wire         wp_on = (wp_n === 1'b0);
    function automatic logic [15:0] qword(input logic [25:0] a);
        if (a >= 26'h57 && a <= 26'h77) return 16'hFFFF;
        case (a)
            26'h52, 26'h79: return 16'h0009;
            26'h53: return 16'h008F;
            26'h54: return 16'h0005;
            26'h55, 26'h56, 26'h78: return 16'h0006;
            default: return a[15:0] ^ 16'h5A3C;
        endcase
    endfunction : qword
    // released bus shows the inverse of the last word
    always_comb dout = (!reset_n || ce_n || oe_n) ? ~last_reg : qword(addr) ^ {16{corrupt}};
    always_ff @(posedge core_clk) if (!reset_n || ce_n || oe_n) ; else last_reg <= dout;
    always_ff @(posedge core_clk)
    begin
        we_reg <= we_n;
        if (!reset_n)
        begin
            busy_reg <= 6'h00;
            fail_reg <= 1'b0;
        end
        else if (we_n && !we_reg && !ce_n)
        begin
            if (wp_on && addr < 26'h10000) fail_reg <= 1'b1;
            else busy_reg <= 6'h28;
        end
        else if (busy_reg != 6'h00) busy_reg <= busy_reg - 6'h01;
    end
    assign rb_pull = fail_reg || busy_reg != 6'h00;
endmodule : pfh_flash_model

// ### pfh_host.sv
`include "pfh_consts.svh"

module pfh_host
(
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     req_valid,
    input  wire logic                     req_write,
    input  wire logic [`PFH_ADDR_W-1:0]   req_addr,
    input  wire logic [`PFH_DATA_W-1:0]   req_wdata,
    input  wire logic                     dev_reset_req,
    input  wire logic                     wp_assert,
    output logic                          req_ready,
    output logic                          rsp_valid,
    output logic [`PFH_DATA_W-1:0]        rsp_rdata,
    output logic                          rsp_query_ok,
    output logic                          dev_ready,
    output logic                          flash_reset_n,
    output logic                          flash_ce_n,
    output logic                          flash_oe_n,
    output logic                          flash_we_n,
    output logic                          flash_wp_n,
    output logic [`PFH_ADDR_W-1:0]        flash_addr,
    output logic [`PFH_DATA_W-1:0]        flash_data_o,
    output logic                          flash_data_oe,
    input  wire logic [`PFH_DATA_W-1:0]   flash_data_i,
    input  wire logic                     flash_ready_busy_n_i,
    output logic                          flash_ready_busy_n_o,
    output logic                          flash_ready_busy_n_oe
);

    // ************************************************************
    // query contents check
    // ************************************************************
    function automatic logic query_match(input logic [`PFH_ADDR_W-1:0] a,
                                         input logic [`PFH_DATA_W-1:0] d);
        logic [7:0] o;
        o = a[7:0];
        query_match = 1'b1;
        if (a[`PFH_ADDR_W-1:8] == '0)
        begin
            if (o == `PFH_Q_OTP_SIZE_OFS)
                query_match = (d == `PFH_Q_OTP_SIZE_VAL);
            else if (o == `PFH_Q_SW_FEAT_OFS)
                query_match = (d == `PFH_Q_SW_FEAT_VAL);
            else if (o == `PFH_Q_PAGE_SIZE_OFS)
                query_match = (d == `PFH_Q_PAGE_SIZE_VAL);
            else if (o == `PFH_Q_ERS_SUSP_OFS || o == `PFH_Q_PGM_SUSP_OFS)
                query_match = (d == `PFH_Q_SUSP_VAL);
            else if (o >= `PFH_Q_RSVD_FIRST_OFS && o <= `PFH_Q_RSVD_LAST_OFS)
                query_match = (d == `PFH_Q_RSVD_VAL);
            else if (o == `PFH_Q_PIN_RST_OFS)
                query_match = (d == `PFH_Q_PIN_RST_VAL);
            else if (o == `PFH_Q_POR_OFS)
                query_match = (d == `PFH_Q_POR_VAL);
        end
    endfunction : query_match

    // ************************************************************
    // ready/busy synchroniser
    // ************************************************************
    logic rb_meta_reg;
    logic rb_sync_reg;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rb_meta_reg <= 1'b0;
            rb_sync_reg <= 1'b0;
        end
        else
        begin
            rb_meta_reg <= flash_ready_busy_n_i;
            rb_sync_reg <= rb_meta_reg;
        end
    end

    // host never pulls the line; pull-up resolves high when released
    always_ff @(posedge core_clk)
    begin
        flash_ready_busy_n_o  <= 1'b0;
        flash_ready_busy_n_oe <= 1'b0;
        dev_ready             <= rst ? 1'b0 : rb_sync_reg;
    end

    // ************************************************************
    // transfer sequencer
    // ************************************************************
    pfh_pkg::pfh_state_t state_reg;
    pfh_pkg::pfh_req_t   req_reg;
    logic [7:0]          cnt_reg;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_reg <= pfh_pkg::PFH_RESET;
            cnt_reg   <= 8'(`PFH_RESET_CYC - 1);
            req_reg   <= '0;
        end
        else
        begin
            case (state_reg)
                pfh_pkg::PFH_IDLE:
                begin
                    if (dev_reset_req)
                    begin
                        state_reg <= pfh_pkg::PFH_RESET;
                        cnt_reg   <= 8'(`PFH_RESET_CYC - 1);
                    end
                    else if (req_valid)
                    begin
                        req_reg.write <= req_write;
                        req_reg.addr  <= req_addr;
                        req_reg.wdata <= req_wdata;
                        state_reg     <= pfh_pkg::PFH_SETUP;
                        cnt_reg       <= 8'(`PFH_SETUP_CYC - 1);
                    end
                end
                pfh_pkg::PFH_SETUP:
                begin
                    cnt_reg <= cnt_reg - 8'h01;
                    if (cnt_reg == 8'h00)
                    begin
                        state_reg <= pfh_pkg::PFH_STROBE;
                        cnt_reg   <= 8'(`PFH_STROBE_CYC - 1);
                    end
                end
                pfh_pkg::PFH_STROBE:
                begin
                    cnt_reg <= cnt_reg - 8'h01;
                    if (cnt_reg == 8'h00)
                    begin
                        state_reg <= pfh_pkg::PFH_HOLD;
                        cnt_reg   <= 8'(`PFH_HOLD_CYC - 1);
                    end
                end
                pfh_pkg::PFH_HOLD:
                begin
                    cnt_reg <= cnt_reg - 8'h01;
                    if (cnt_reg == 8'h00)
                        state_reg <= pfh_pkg::PFH_IDLE;
                end
                pfh_pkg::PFH_RESET:
                begin
                    cnt_reg <= cnt_reg - 8'h01;
                    if (cnt_reg == 8'h00)
                        state_reg <= pfh_pkg::PFH_IDLE;
                end
                default:
                    state_reg <= pfh_pkg::PFH_IDLE;
            endcase
        end
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    logic strobe_last;
    assign strobe_last = (state_reg == pfh_pkg::PFH_STROBE) && (cnt_reg == 8'h00);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            flash_reset_n <= 1'b0;
            flash_ce_n    <= 1'b1;
            flash_oe_n    <= 1'b1;
            flash_we_n    <= 1'b1;
            flash_addr    <= '0;
            flash_data_o  <= '0;
            flash_data_oe <= 1'b0;
        end
        else
        begin
            flash_reset_n <= ~(state_reg == pfh_pkg::PFH_RESET
                               || (state_reg == pfh_pkg::PFH_IDLE && dev_reset_req));
            flash_ce_n    <= ~(state_reg == pfh_pkg::PFH_SETUP
                               || state_reg == pfh_pkg::PFH_STROBE
                               || state_reg == pfh_pkg::PFH_HOLD);
            // strobes are exclusive by construction
            flash_we_n    <= ~(state_reg == pfh_pkg::PFH_STROBE && req_reg.write
                               && !strobe_last);
            flash_oe_n    <= ~(state_reg == pfh_pkg::PFH_STROBE && !req_reg.write
                               && !strobe_last);
            flash_addr    <= req_reg.addr;
            flash_data_o  <= req_reg.wdata;
            flash_data_oe <= (state_reg != pfh_pkg::PFH_IDLE
                              && state_reg != pfh_pkg::PFH_RESET
                              && req_reg.write);
        end
    end

    // write-protect drive; device defaults to unprotected when released
    always_ff @(posedge core_clk)
    begin
        flash_wp_n <= rst ? 1'b1 : ~wp_assert;
    end

    // ************************************************************
    // user answer
    // ************************************************************
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            req_ready    <= 1'b0;
            rsp_valid    <= 1'b0;
            rsp_rdata    <= '0;
            rsp_query_ok <= 1'b0;
        end
        else
        begin
            req_ready <= (state_reg == pfh_pkg::PFH_HOLD && cnt_reg == 8'h00)
                         || (state_reg == pfh_pkg::PFH_IDLE && !req_valid && !dev_reset_req);
            rsp_valid <= strobe_last;
            if (strobe_last && !req_reg.write)
            begin
                rsp_rdata    <= flash_data_i;
                rsp_query_ok <= query_match(req_reg.addr, flash_data_i);
            end
        end
    end

endmodule : pfh_host

// ### pfh_host_monitor.sv
`include "pfh_consts.svh"
module pfh_host_monitor
(
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire logic                   wp_assert,
    input wire logic                   dev_ready,
    input wire logic                   flash_reset_n,
    input wire logic                   flash_ce_n,
    input wire logic                   flash_oe_n,
    input wire logic                   flash_we_n,
    input wire logic                   flash_wp_n,
    input wire logic [`PFH_ADDR_W-1:0] flash_addr,
    input wire logic                   flash_data_oe,
    input wire logic                   flash_ready_busy_n_i,
    input wire logic                   flash_ready_busy_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_strobe_excl: assert property (flash_oe_n || flash_we_n)
        else $error("strobes low together");
    a_read_select: assert property (!flash_oe_n |-> !flash_ce_n && !flash_data_oe)
        else $error("read strobe without select or with host drive");
    a_write_select: assert property (!flash_we_n |-> !flash_ce_n && flash_data_oe)
        else $error("write strobe without select or data");
    a_addr_hold: assert property (!flash_ce_n && $past(flash_ce_n) == 1'b0 |-> $stable(flash_addr))
        else $error("address moved during select");
    a_wp_level: assert property (!$past(rst) |-> flash_wp_n == !$past(wp_assert))
        else $error("write protect pin wrong");
    a_ready_high: assert property (flash_ready_busy_n_i [*4] |=> dev_ready)
        else $error("ready not seen");
    a_busy_low: assert property (!flash_ready_busy_n_i [*4] |=> !dev_ready)
        else $error("busy not seen");
    a_host_release: assert property (!flash_ready_busy_n_oe)
        else $error("host pulls ready line");
    a_reset_quiet: assert property (!flash_reset_n |-> flash_ce_n && flash_oe_n && flash_we_n)
        else $error("strobe active in device reset");
endmodule : pfh_host_monitor

bind pfh_host pfh_host_monitor pfh_host_monitor_inst (.core_clk, .rst, .wp_assert, .dev_ready,
    .flash_reset_n, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_wp_n, .flash_addr,
    .flash_data_oe, .flash_ready_busy_n_i, .flash_ready_busy_n_oe);

// ### pfh_host_test.sv
`include "pfh_consts.svh"
module pfh_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst, req_valid, req_write, dev_reset_req, wp_assert, corrupt;
    logic        req_ready, rsp_valid, rsp_query_ok, dev_ready, rb_pull;
    logic        flash_reset_n, flash_ce_n, flash_oe_n, flash_we_n, flash_wp_n;
    logic        flash_data_oe, flash_ready_busy_n_i, flash_ready_busy_n_o, flash_ready_busy_n_oe;
    logic [25:0] req_addr, flash_addr;
    logic [15:0] req_wdata, rsp_rdata, flash_data_o, flash_data_i, dev_dout;
    logic [31:0] lfsr;
    int          err_total, cmp_count, i;
    logic [15:0] exp_q[$];
    pfh_host pfh_host_inst (.core_clk, .rst, .req_valid, .req_write, .req_addr, .req_wdata,
        .dev_reset_req, .wp_assert, .req_ready, .rsp_valid, .rsp_rdata, .rsp_query_ok,
        .dev_ready, .flash_reset_n, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_wp_n,
        .flash_addr, .flash_data_o, .flash_data_oe, .flash_data_i, .flash_ready_busy_n_i,
        .flash_ready_busy_n_o, .flash_ready_busy_n_oe);
    pfh_flash_model pfh_flash_model_inst (.core_clk, .reset_n(flash_reset_n), .ce_n(flash_ce_n),
        .oe_n(flash_oe_n), .we_n(flash_we_n), .wp_n(flash_wp_n), .addr(flash_addr), .corrupt,
        .dout(dev_dout), .rb_pull);
    assign flash_data_i = flash_data_oe ? flash_data_o : dev_dout;
    assign flash_ready_busy_n_i = !(rb_pull || (flash_ready_busy_n_oe && !flash_ready_busy_n_o));
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    function automatic logic [15:0] exp_word(input logic [25:0] a);
        if (a >= 26'h57 && a <= 26'h77) return 16'hFFFF;
        case (a)
            26'h52, 26'h79: return 16'h0009;
            26'h53: return 16'h008F;
            26'h54: return 16'h0005;
            26'h55, 26'h56, 26'h78: return 16'h0006;
            default: return a[15:0] ^ 16'h5A3C;
        endcase
    endfunction : exp_word
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : lfsr_next
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic xfer(input logic w, input logic [25:0] a, input logic [15:0] d);
        int          n;
        logic [15:0] exp_ok;
        n = 0;
        exp_ok = {15'h0, !(corrupt && a >= 26'h52 && a <= 26'h79)};
        if (!w) exp_q.push_back(exp_word(a) ^ {16{corrupt}});
        while (req_ready !== 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("rsp_valid", {15'h0, rsp_valid}, 16'h0001);
        check("req_ready", {15'h0, req_ready}, 16'h0000);
        check("addr_lo", flash_addr[15:0], a[15:0]);
        check("addr_hi", {6'h0, flash_addr[25:16]}, {6'h0, a[25:16]});
        check("data_oe", {15'h0, flash_data_oe}, {15'h0, w});
        if (w) check("data_o", flash_data_o, d);
        if (!w) check("rsp_rdata", rsp_rdata, exp_q.pop_front());
        if (!w) check("query_ok", {15'h0, rsp_query_ok}, exp_ok);
    endtask : xfer
    // ************
    // main sequence
    // ************
    initial
    begin
        {rst, req_valid, req_write, dev_reset_req, wp_assert, corrupt} = 6'h20;
        {req_addr, req_wdata, err_total, cmp_count} = '0;
        lfsr = 32'hB48A;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        check("wp_pin", {15'h0, flash_wp_n}, 16'h0001);
        for (i = 'h52; i <= 'h79; i++) xfer(1'b0, 26'(i), 16'h0000);
        repeat (8)
        begin
            lfsr = lfsr_next(lfsr);
            xfer(1'b0, lfsr[25:0], 16'h0000);
        end
        corrupt = 1'b1;
        xfer(1'b0, 26'h53, 16'h0000);
        xfer(1'b0, 26'h100, 16'h0000);
        corrupt = 1'b0;
        xfer(1'b1, 26'h20000, lfsr[15:0]);
        repeat (8) @(negedge core_clk);
        check("busy", {15'h0, dev_ready}, 16'h0000);
        repeat (60) @(negedge core_clk);
        check("ready", {15'h0, dev_ready}, 16'h0001);
        wp_assert = 1'b1;
        repeat (2) @(negedge core_clk);
        check("wp_pin", {15'h0, flash_wp_n}, 16'h0000);
        xfer(1'b1, 26'h100, lfsr[31:16]);
        repeat (80) @(negedge core_clk);
        check("fail_busy", {15'h0, dev_ready}, 16'h0000);
        wait (req_ready === 1'b1);
        @(negedge core_clk);
        dev_reset_req = 1'b1;
        @(negedge core_clk);
        dev_reset_req = 1'b0;
        repeat (5) @(negedge core_clk);
        check("reset_pins", {14'h0, flash_reset_n, flash_ce_n}, 16'h0001);
        wp_assert = 1'b0;
        repeat (130) @(negedge core_clk);
        check("ready_after", {15'h0, dev_ready}, 16'h0001);
        xfer(1'b0, 26'h79, 16'h0000);
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        conclude();
    end
endmodule : pfh_host_test

// ### pfh_pkg.sv
package pfh_pkg;

    typedef enum logic [4:0] {
        PFH_IDLE   = 5'h01,
        PFH_SETUP  = 5'h02,
        PFH_STROBE = 5'h04,
        PFH_HOLD   = 5'h08,
        PFH_RESET  = 5'h10
    } pfh_state_t;

    // user request
    typedef struct packed {
        logic        write;
        logic [25:0] addr;
        logic [15:0] wdata;
    } pfh_req_t;

    // pin drive toward the device
    typedef struct packed {
        logic        reset_n;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        wp_n;
        logic [25:0] addr;
        logic [15:0] dout;
        logic        doe;
    } pfh_pins_t;

endpackage : pfh_pkg
